//--- fsfo_pkg.sv
// Shared constants, field layouts and timing for the fail-output block and its controller
package fsfo_pkg;

  // ==========================================================
  // Timing base
  localparam longint unsigned FS_CLK_HZ = 125_000_000;
  localparam longint unsigned BLINK_FREQ_MILLIHZ = 1250;
  localparam longint unsigned BLINK_DUTY_PCT = 50;
  localparam longint unsigned DIM_FREQ_HZ = 100;
  localparam longint unsigned DIM_DUTY_PCT = 20;
  localparam longint unsigned FAILSAFE_WINDOW_US = 1000;
  localparam longint unsigned TOGGLE_HALF_US = 125;

  localparam int unsigned BLINK_PERIOD_CYC = 32'(FS_CLK_HZ * 64'd1000 / BLINK_FREQ_MILLIHZ);
  localparam int unsigned BLINK_ON_CYC = 32'(64'(BLINK_PERIOD_CYC) * BLINK_DUTY_PCT / 64'd100);
  localparam int unsigned DIM_PERIOD_CYC = 32'(FS_CLK_HZ / DIM_FREQ_HZ);
  localparam int unsigned DIM_ON_CYC = 32'(64'(DIM_PERIOD_CYC) * DIM_DUTY_PCT / 64'd100);
  localparam int unsigned FAILSAFE_WINDOW_CYC = 32'(FS_CLK_HZ * FAILSAFE_WINDOW_US / 64'd1000000);
  localparam logic [31:0] TOGGLE_HALF_CYC = 32'(FS_CLK_HZ * TOGGLE_HALF_US / 64'd1000000);

  // ==========================================================
  // Device registers reached over the link
  localparam int unsigned STAT_FO_BIT = 0;
  localparam int unsigned STAT_WD_BIT = 1;
  localparam int unsigned STAT_MISS_BIT = 2;
  localparam int unsigned CTRL_WDSEL_BIT = 0;
  localparam int unsigned CTRL_FSIDIS_BIT = 1;
  localparam logic [7:0] CTRL_REG_RESET = 8'h00;

  // ==========================================================
  // Controller registers on AHB-Lite
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] HALF_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS = 8'h08;
  localparam logic [7:0] RESP_OFS = 8'h0C;
  localparam logic [7:0] PINS_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS = 8'h18;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h1C;
  localparam int unsigned CMD_SEL_BIT = 8;
  localparam int unsigned CMD_WR_BIT = 9;
  localparam int unsigned RESP_BUSY_BIT = 8;
  localparam int unsigned IRQ_CMD_BIT = 0;
  localparam int unsigned IRQ_FAIL_BIT = 1;
  localparam int unsigned IRQ_W = 2;

  typedef enum logic [0:0] {FSFO_IDLE = 1'b0, FSFO_WAIT = 1'b1} fsfo_cmd_state_t;

endpackage

//--- fsfo_link_if.sv
// Pins and command link between the fail-output device and its controller
`timescale 1ns/100ps
`default_nettype none
interface fsfo_link_if;
  logic cmd_valid;
  logic cmd_write;
  logic cmd_sel;
  logic [7:0] cmd_wdata;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  logic static_oe;
  logic blink_oe;
  logic dim_oe;
  logic toggle_out;
  logic toggle_oe;
  logic static_level;
  logic blink_level;
  logic dim_level;

  // ==========================================================
  // Pin resolution: low-side switches pull low, otherwise pulled high; the blink pin follows toggle_out while toggle_oe
  assign static_level = ~static_oe;
  assign dim_level = ~dim_oe;
  assign blink_level = ~blink_oe & (toggle_oe ? toggle_out : 1'b1);

  modport device (input cmd_valid, cmd_write, cmd_sel, cmd_wdata, blink_level,
                  output rsp_valid, rsp_rdata, static_oe, blink_oe, dim_oe);
  modport host (output cmd_valid, cmd_write, cmd_sel, cmd_wdata, toggle_out, toggle_oe,
                input rsp_valid, rsp_rdata, static_level, blink_level, dim_level);
endinterface
`default_nettype wire

//--- fsfo_device.sv
// Fail-output logic and fail-safe input monitor of the device end
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Any failure turns outputs on, sets flag
// - Watchdog trigger failures activate fail outputs
// - Control bit picks first or second failure
// - Thermal, regulator short, reset clamp activate
// - Off only when clean and flag cleared
// - Watchdog hold needs good trigger, flag cleared
// - Activation independent of fail-safe mode
// - All three outputs start together
// - Static output held low while active
// - Blink output 1.25 Hz, half on
// - Dimmed output 100 Hz, 20 percent on
// - Controller toggles pin, device catches rises
// - Monitor on at reset, disable bit stops
// - Missed edge sets flag, static and dimmed
// - Missed edge causes no mode, reset, interrupt; the controller still sets its fail interrupt when the static pin falls
// - Missing flag clears only after fresh rise
// - Monitor works only in normal mode
module fsfo_device #(
  parameter int unsigned BLINK_PERIOD = fsfo_pkg::BLINK_PERIOD_CYC,
  parameter int unsigned BLINK_ON = fsfo_pkg::BLINK_ON_CYC,
  parameter int unsigned DIM_PERIOD = fsfo_pkg::DIM_PERIOD_CYC,
  parameter int unsigned DIM_ON = fsfo_pkg::DIM_ON_CYC,
  parameter int unsigned FAILSAFE_WINDOW = fsfo_pkg::FAILSAFE_WINDOW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  fsfo_link_if.device link,
  input wire logic wd_trigger_fail,
  input wire logic wd_trigger_ok,
  input wire logic thermal_shutdown_level_two,
  input wire logic main_regulator_out_short,
  input wire logic reset_out_pin_clamped_high,
  input wire logic normal_mode,
  output logic fail_output_active_flag,
  output logic failsafe_input_missing_flag
);

  if (BLINK_ON < 1 || BLINK_ON >= BLINK_PERIOD || DIM_ON < 1 || DIM_ON >= DIM_PERIOD || FAILSAFE_WINDOW < 2)
  begin : g_check
    $error("fsfo_device: timing parameters out of range");
  end

  logic [7:0] hardware_control_register;
  logic watchdog_failure_flag;
  logic wd_ok_seen;
  logic wd_prev_fail;
  logic wd_hold;
  logic edge_seen;
  logic blink_prev;
  logic [31:0] blink_cnt;
  logic [31:0] dim_cnt;
  logic [31:0] win_cnt;
  logic wr_ctrl;
  logic wr_stat;
  logic wd_trip;
  logic cond_now;
  logic any_fail_out;
  logic monitor_on;
  logic pin_rise;
  logic window_miss;

  // ==========================================================
  // Command decode
  assign wr_ctrl = link.cmd_valid & link.cmd_write & link.cmd_sel;
  assign wr_stat = link.cmd_valid & link.cmd_write & ~link.cmd_sel;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hardware_control_register <= fsfo_pkg::CTRL_REG_RESET;
    else if (wr_ctrl)
      hardware_control_register <= link.cmd_wdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link.rsp_valid <= 1'b0;
      link.rsp_rdata <= 8'h00;
    end
    else
    begin
      link.rsp_valid <= link.cmd_valid;
      if (link.cmd_valid && !link.cmd_write)
        link.rsp_rdata <= link.cmd_sel ? hardware_control_register :
                          {5'h00, failsafe_input_missing_flag, watchdog_failure_flag, fail_output_active_flag};
    end
  end

  // ==========================================================
  // Watchdog failure tracking
  // first or second failure
  assign wd_trip = wd_trigger_fail &
                   (~hardware_control_register[fsfo_pkg::CTRL_WDSEL_BIT] | wd_prev_fail);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_prev_fail <= 1'b0;
    else if (wd_trigger_ok)
      wd_prev_fail <= 1'b0;
    else if (wd_trigger_fail)
      wd_prev_fail <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_ok_seen <= 1'b0;
    else if (wd_trigger_fail)
      wd_ok_seen <= 1'b0;
    else if (wd_trigger_ok)
      wd_ok_seen <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      watchdog_failure_flag <= 1'b0;
    else if (wd_trigger_fail)
      watchdog_failure_flag <= 1'b1;
    else if (wr_stat && link.cmd_wdata[fsfo_pkg::STAT_WD_BIT] && wd_ok_seen)
      watchdog_failure_flag <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wd_hold <= 1'b0;
    else if (wd_trip)
      wd_hold <= 1'b1;
    else if (!watchdog_failure_flag && wd_ok_seen)
      wd_hold <= 1'b0;
  end

  // ==========================================================
  // Fail-output activation
  // live failure conditions
  assign cond_now = thermal_shutdown_level_two | main_regulator_out_short | reset_out_pin_clamped_high | wd_hold;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fail_output_active_flag <= 1'b0;
    else if (cond_now || wd_trip)
      fail_output_active_flag <= 1'b1;
    else if (wr_stat && link.cmd_wdata[fsfo_pkg::STAT_FO_BIT])
      fail_output_active_flag <= 1'b0;
  end

  assign any_fail_out = fail_output_active_flag | failsafe_input_missing_flag;

  // ==========================================================
  // Fail-safe input monitor
  // Paused while the blinking output drives the shared pin, else it would see its own edges
  // normal mode only
  assign monitor_on = normal_mode & ~hardware_control_register[fsfo_pkg::CTRL_FSIDIS_BIT] &
                      ~fail_output_active_flag;
  assign pin_rise = link.blink_level & ~blink_prev;
  assign window_miss = monitor_on & ~pin_rise & (win_cnt == FAILSAFE_WINDOW - 1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      blink_prev <= 1'b1;
    else
      blink_prev <= link.blink_level;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      win_cnt <= 32'h0000_0000;
    else if (!monitor_on || pin_rise || window_miss)
      win_cnt <= 32'h0000_0000;
    else
      win_cnt <= win_cnt + 32'h0000_0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      edge_seen <= 1'b0;
    else if (window_miss)
      edge_seen <= 1'b0;
    else if (pin_rise)
      edge_seen <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      failsafe_input_missing_flag <= 1'b0;
    else if (window_miss)
      failsafe_input_missing_flag <= 1'b1;
    else if (wr_stat && link.cmd_wdata[fsfo_pkg::STAT_MISS_BIT] && (edge_seen || pin_rise))
      failsafe_input_missing_flag <= 1'b0;
  end

  // ==========================================================
  // Output waveforms
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      blink_cnt <= 32'h0000_0000;
    else if (!fail_output_active_flag || blink_cnt == BLINK_PERIOD - 1)
      blink_cnt <= 32'h0000_0000;
    else
      blink_cnt <= blink_cnt + 32'h0000_0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dim_cnt <= 32'h0000_0000;
    else if (!any_fail_out || dim_cnt == DIM_PERIOD - 1)
      dim_cnt <= 32'h0000_0000;
    else
      dim_cnt <= dim_cnt + 32'h0000_0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link.static_oe <= 1'b0;
      link.blink_oe <= 1'b0;
      link.dim_oe <= 1'b0;
    end
    else
    begin
      link.static_oe <= any_fail_out;
      link.blink_oe <= fail_output_active_flag & (blink_cnt < BLINK_ON);
      link.dim_oe <= any_fail_out & (dim_cnt < DIM_ON);
    end
  end

endmodule
`default_nettype wire

//--- fsfo_controller.sv
// Controller end: AHB-Lite registers, command issue, fail-safe input toggling, interrupt
`timescale 1ns/100ps
`default_nettype none
module fsfo_controller (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  fsfo_link_if.host link
);

  logic wr_pend;
  logic [7:0] wr_addr;
  logic toggle_en;
  logic [31:0] half_cyc;
  logic [31:0] tog_cnt;
  logic [7:0] resp_data;
  logic [fsfo_pkg::IRQ_W-1:0] irq_stat;
  logic [fsfo_pkg::IRQ_W-1:0] irq_en;
  logic [fsfo_pkg::IRQ_W-1:0] irq_clr;
  logic [fsfo_pkg::IRQ_W-1:0] irq_ev;
  logic static_prev;
  logic acc;
  logic wr_cmd;
  logic [31:0] rd_mux;
  fsfo_pkg::fsfo_cmd_state_t state;

  // ==========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  assign acc = hsel & htrans[1] & hready;
  assign wr_cmd = wr_pend & (wr_addr == fsfo_pkg::CMD_OFS) & (state == fsfo_pkg::FSFO_IDLE);
  assign irq_clr = (wr_pend && wr_addr == fsfo_pkg::IRQ_CLR_OFS) ? hwdata[fsfo_pkg::IRQ_W-1:0] : '0;

  always_comb
  begin
    unique case (haddr[7:0])
      fsfo_pkg::CTRL_OFS: rd_mux = {31'h0000_0000, toggle_en};
      fsfo_pkg::HALF_OFS: rd_mux = half_cyc;
      fsfo_pkg::RESP_OFS: rd_mux = {23'h00_0000, state == fsfo_pkg::FSFO_WAIT, resp_data};
      fsfo_pkg::PINS_OFS: rd_mux = {29'h0000_0000, link.dim_level, link.blink_level, link.static_level};
      fsfo_pkg::IRQ_STAT_OFS: rd_mux = {30'h0000_0000, irq_stat};
      fsfo_pkg::IRQ_EN_OFS: rd_mux = {30'h0000_0000, irq_en};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= acc & hwrite;
      if (acc)
        wr_addr <= haddr[7:0];
      if (acc && !hwrite)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      toggle_en <= 1'b0;
      half_cyc <= fsfo_pkg::TOGGLE_HALF_CYC;
      irq_en <= '0;
    end
    else if (wr_pend)
    begin
      if (wr_addr == fsfo_pkg::CTRL_OFS)
        toggle_en <= hwdata[0];
      if (wr_addr == fsfo_pkg::HALF_OFS)
        half_cyc <= (hwdata == 32'h0000_0000) ? 32'h0000_0001 : hwdata;
      if (wr_addr == fsfo_pkg::IRQ_EN_OFS)
        irq_en <= hwdata[fsfo_pkg::IRQ_W-1:0];
    end
  end

  // ==========================================================
  // Command engine; writes to CMD while busy are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= fsfo_pkg::FSFO_IDLE;
      link.cmd_valid <= 1'b0;
      link.cmd_write <= 1'b0;
      link.cmd_sel <= 1'b0;
      link.cmd_wdata <= 8'h00;
      resp_data <= 8'h00;
    end
    else
    begin
      link.cmd_valid <= wr_cmd;
      unique case (state)
        fsfo_pkg::FSFO_IDLE:
          if (wr_cmd)
          begin
            state <= fsfo_pkg::FSFO_WAIT;
            link.cmd_write <= hwdata[fsfo_pkg::CMD_WR_BIT];
            link.cmd_sel <= hwdata[fsfo_pkg::CMD_SEL_BIT];
            link.cmd_wdata <= hwdata[7:0];
          end
        fsfo_pkg::FSFO_WAIT:
          if (link.rsp_valid)
          begin
            state <= fsfo_pkg::FSFO_IDLE;
            if (!link.cmd_write)
              resp_data <= link.rsp_rdata;
          end
      endcase
    end
  end

  // ==========================================================
  // Fail-safe input toggling, driven push-pull while enabled
  // periodic rising edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tog_cnt <= 32'h0000_0000;
      link.toggle_out <= 1'b0;
      link.toggle_oe <= 1'b0;
    end
    else
    begin
      link.toggle_oe <= toggle_en;
      if (!toggle_en || tog_cnt >= half_cyc - 32'h0000_0001)
        tog_cnt <= 32'h0000_0000;
      else
        tog_cnt <= tog_cnt + 32'h0000_0001;
      if (toggle_en && tog_cnt >= half_cyc - 32'h0000_0001)
        link.toggle_out <= ~link.toggle_out;
    end
  end

  // ==========================================================
  // Interrupt: set wins over clear
  assign irq_ev[fsfo_pkg::IRQ_CMD_BIT] = (state == fsfo_pkg::FSFO_WAIT) & link.rsp_valid;
  assign irq_ev[fsfo_pkg::IRQ_FAIL_BIT] = static_prev & ~link.static_level;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      static_prev <= 1'b1;
      irq_stat <= '0;
      irq <= 1'b0;
    end
    else
    begin
      static_prev <= link.static_level;
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      irq <= |(((irq_stat & ~irq_clr) | irq_ev) & irq_en);
    end
  end

endmodule
`default_nettype wire

//--- fsfo_link_properties.sv
// Concurrent checks on the link between the fail-output device and its controller
`timescale 1ns/100ps
`default_nettype none
module fsfo_link_properties #(
  parameter int unsigned BLINK_ON = 10,
  parameter int unsigned DIM_PERIOD = 10,
  parameter int unsigned DIM_ON = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cmd_valid,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata,
  input wire logic static_oe,
  input wire logic blink_oe,
  input wire logic dim_oe
);
  // ==========================================================
  // Run lengths of the pulsed outputs
  logic [31:0] b_hi;
  logic [31:0] d_hi;
  logic [31:0] d_lo;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      b_hi <= 32'h0;
    else
      b_hi <= blink_oe ? b_hi + 32'h1 : 32'h0;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      d_hi <= 32'h0;
    else
      d_hi <= dim_oe ? d_hi + 32'h1 : 32'h0;
  // Low phase only counts while static is on, so a fresh activation never looks short
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      d_lo <= 32'h0;
    else
      d_lo <= (!dim_oe && static_oe) ? d_lo + 32'h1 : 32'h0;

  // ==========================================================
  // Properties
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_cmd;
    cmd_valid;
  endsequence
  sequence s_answer;
    ##1 rsp_valid;
  endsequence
  a_rsp_follows_cmd: assert property (s_cmd |-> s_answer)
    else $error("no answer one cycle after command");
  a_rsp_has_cause: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without command");
  a_cmd_one_outstanding: assert property (cmd_valid |=> !cmd_valid [*2])
    else $error("commands too close");
  a_rdata_holds: assert property (!rsp_valid |-> $stable(rsp_rdata))
    else $error("read data moved without answer");
  a_outputs_together: assert property ($rose(static_oe) |-> dim_oe)
    else $error("dimmed output late at activation");
  a_blink_joins_start: assert property ($rose(blink_oe) && !$past(static_oe) |-> static_oe && dim_oe)
    else $error("blink output started alone");
  a_static_holds_low: assert property (blink_oe |-> static_oe)
    else $error("static output off while blinking");
  a_blink_on_len: assert property ($fell(blink_oe) && static_oe |-> b_hi == BLINK_ON)
    else $error("blink on phase wrong length");
  a_dim_on_len: assert property ($fell(dim_oe) && static_oe |-> d_hi == DIM_ON)
    else $error("dimmed on phase wrong length");
  a_dim_off_len: assert property ($rose(dim_oe) && $past(static_oe) |-> d_lo == DIM_PERIOD - DIM_ON)
    else $error("dimmed off phase wrong length");
endmodule
`default_nettype wire

//--- failsafe_outputs_and_input_test.sv
// Testbench joining controller and device, driven over AHB-Lite
`timescale 1ns/100ps
`default_nettype none
module failsafe_outputs_and_input_test;
  // Short periods keep the run brief
  localparam int unsigned T_BP = 20;
  localparam int unsigned T_BO = 10;
  localparam int unsigned T_DP = 10;
  localparam int unsigned T_DO = 2;
  localparam int unsigned T_WIN = 50;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic irq;
  logic wd_bad = 1'b0;
  logic wd_ok = 1'b0;
  logic cond [3] = '{1'b0, 1'b0, 1'b0};
  logic normal_mode = 1'b0;
  logic fo;
  logic miss_flag;
  logic [31:0] rd;
  int mismatches = 0;
  int samples_checked = 0;

  fsfo_link_if link ();
  fsfo_controller u_fsfo_controller (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link));
  fsfo_device #(.BLINK_PERIOD(T_BP), .BLINK_ON(T_BO), .DIM_PERIOD(T_DP), .DIM_ON(T_DO),
    .FAILSAFE_WINDOW(T_WIN)) u_fsfo_device (.hclk(hclk), .hresetn(hresetn), .link(link),
    .wd_trigger_fail(wd_bad), .wd_trigger_ok(wd_ok), .thermal_shutdown_level_two(cond[0]),
    .main_regulator_out_short(cond[1]), .reset_out_pin_clamped_high(cond[2]),
    .normal_mode(normal_mode), .fail_output_active_flag(fo), .failsafe_input_missing_flag(miss_flag));
  fsfo_link_properties #(.BLINK_ON(T_BO), .DIM_PERIOD(T_DP), .DIM_ON(T_DO)) u_fsfo_link_properties (
    .hclk(hclk), .hresetn(hresetn), .cmd_valid(link.cmd_valid), .rsp_valid(link.rsp_valid),
    .rsp_rdata(link.rsp_rdata), .static_oe(link.static_oe), .blink_oe(link.blink_oe),
    .dim_oe(link.dim_oe));

  always #4 hclk = ~hclk;

  // ==========================================================
  // Tasks
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // Address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
    chk1(hresp, 1'b0);
  endtask
  // Poll busy; the watchdog catches a command that never finishes
  task automatic cmd(input logic w, input logic s, input logic [7:0] d);
    xfer(1'b1, fsfo_pkg::CMD_OFS, {22'h0, w, s, d});
    do xfer(1'b0, fsfo_pkg::RESP_OFS, 32'h0); while (rd[fsfo_pkg::RESP_BUSY_BIT] !== 1'b0);
  endtask
  task automatic dchk(input logic s, input logic [7:0] e);
    cmd(1'b0, s, 8'h00);
    chk({24'h0, rd[7:0]}, {24'h0, e});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic wd(input logic ok);
    @(posedge hclk);
    wd_ok <= ok;
    wd_bad <= ~ok;
    @(posedge hclk);
    wd_ok <= 1'b0;
    wd_bad <= 1'b0;
    step(3);
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    #160000;
    mismatches++;
    end_sim();
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(fsfo_pkg::PINS_OFS, 32'h7, 32'h7);
    dchk(1'b0, 8'h00);
    dchk(1'b1, fsfo_pkg::CTRL_REG_RESET);
    xfer(1'b1, fsfo_pkg::IRQ_EN_OFS, 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge hclk);
      cond[i] <= 1'b1;
      step(3);
      chk1(fo, 1'b1);
      rchk(fsfo_pkg::PINS_OFS, 32'h1, 32'h0);
      chk1(irq, 1'b1);
      cmd(1'b1, 1'b0, 8'h01);
      dchk(1'b0, 8'h01);
      @(posedge hclk);
      cond[i] <= 1'b0;
      cmd(1'b1, 1'b0, 8'h01);
      dchk(1'b0, 8'h00);
      rchk(fsfo_pkg::PINS_OFS, 32'h1, 32'h1);
      xfer(1'b1, fsfo_pkg::IRQ_CLR_OFS, 32'h3);
      step(2);
      chk1(irq, 1'b0);
    end
    // Command-done event masked, then enabled, then cleared
    xfer(1'b1, fsfo_pkg::IRQ_EN_OFS, 32'h0);
    dchk(1'b1, 8'h00);
    rchk(fsfo_pkg::IRQ_STAT_OFS, 32'h3, 32'h1);
    chk1(irq, 1'b0);
    xfer(1'b1, fsfo_pkg::IRQ_EN_OFS, 32'h1);
    step(2);
    chk1(irq, 1'b1);
    xfer(1'b1, fsfo_pkg::IRQ_CLR_OFS, 32'h3);
    step(2);
    chk1(irq, 1'b0);
    rchk(fsfo_pkg::IRQ_CLR_OFS, 32'hFFFFFFFF, 32'h0);
    rchk(8'h20, 32'hFFFFFFFF, 32'h0);
    wd(1'b0);
    chk1(fo, 1'b1);
    dchk(1'b0, 8'h03);
    cmd(1'b1, 1'b0, 8'h03);
    dchk(1'b0, 8'h03);
    wd(1'b1);
    cmd(1'b1, 1'b0, 8'h02);
    cmd(1'b1, 1'b0, 8'h01);
    dchk(1'b0, 8'h00);
    cmd(1'b1, 1'b1, 8'h01);
    wd(1'b0);
    chk1(fo, 1'b0);
    wd(1'b1);
    wd(1'b0);
    chk1(fo, 1'b0);
    wd(1'b0);
    chk1(fo, 1'b1);
    step(50);
    rchk(fsfo_pkg::PINS_OFS, 32'h1, 32'h0);
    wd(1'b1);
    cmd(1'b1, 1'b0, 8'h02);
    cmd(1'b1, 1'b0, 8'h01);
    dchk(1'b0, 8'h00);
    // Fail-safe input: toggled, then silent, then refused and accepted clears
    cmd(1'b1, 1'b1, 8'h00);
    xfer(1'b1, fsfo_pkg::HALF_OFS, 32'h5);
    xfer(1'b1, fsfo_pkg::CTRL_OFS, 32'h1);
    @(posedge hclk);
    normal_mode <= 1'b1;
    step(200);
    chk1(miss_flag, 1'b0);
    xfer(1'b1, fsfo_pkg::CTRL_OFS, 32'h0);
    step(120);
    chk1(miss_flag, 1'b1);
    chk1(fo, 1'b0);
    rchk(fsfo_pkg::PINS_OFS, 32'h1, 32'h0);
    cmd(1'b1, 1'b0, 8'h04);
    dchk(1'b0, 8'h04);
    xfer(1'b1, fsfo_pkg::CTRL_OFS, 32'h1);
    step(30);
    cmd(1'b1, 1'b0, 8'h04);
    dchk(1'b0, 8'h00);
    cmd(1'b1, 1'b1, 8'h02);
    xfer(1'b1, fsfo_pkg::CTRL_OFS, 32'h0);
    step(120);
    chk1(miss_flag, 1'b0);
    @(posedge hclk);
    normal_mode <= 1'b0;
    cmd(1'b1, 1'b1, 8'h00);
    step(120);
    chk1(miss_flag, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
